/* File: rtl/mbpwm_timer.sv */
`timescale 1ns/10ps
module mbpwm_timer #(
  parameter int N_MATCH = mbpwm_pkg::N_MATCH,
  parameter int N_OUT   = mbpwm_pkg::N_OUT
) (
  input  wire logic                          ref_clk_i,
  input  wire logic                          reset_i,
  input  wire logic [mbpwm_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [31:0]                   wdata_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [31:0]                   rdata_o,
  output logic      [N_OUT-1:0]              pwm_o,
  output logic                               irq_o
);
  mbpwm_pkg::mbpwm_req_t req;
  assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

  // widths and address window of the match registers
  localparam int AW = mbpwm_pkg::ADDR_W;
  localparam logic [AW-1:0] MATCH_SPAN = mbpwm_pkg::A_STEP * AW'(N_MATCH);
  localparam logic [AW-1:0] WORD_MASK  = mbpwm_pkg::A_STEP - AW'(1);

  // decode a match register index from an address
  function automatic logic [3:0] match_idx(input logic [mbpwm_pkg::ADDR_W-1:0] a);
    logic [mbpwm_pkg::ADDR_W-1:0] d;
    d = a - mbpwm_pkg::A_MATCH0;
    return d[5:2];
  endfunction

  // true only on an implemented, word-aligned match register, so no alias higher up
  function automatic logic is_match_addr(input logic [AW-1:0] a);
    logic [AW-1:0] d;
    d = a - mbpwm_pkg::A_MATCH0;
    return (a >= mbpwm_pkg::A_MATCH0) && (d < MATCH_SPAN) && ((d & WORD_MASK) == '0);
  endfunction

  logic [31:0]      ctrl_r;
  logic [31:0]      action_r;
  logic [31:0]      mode_r;
  logic [N_MATCH-1:0] stat_r;
  logic [N_MATCH-1:0] mask_r;
  logic [31:0]      match_r [N_MATCH];
  logic [mbpwm_pkg::CNT_W-1:0] count_r;
  logic [31:0]      rdata_r;
  logic [N_OUT-1:0] pwm_r;
  logic             irq_r;

  // address decode
  wire in_match = is_match_addr(req.addr);
  wire [3:0] widx = match_idx(req.addr);

  // register write strobes
  wire wr_ctrl   = req.wr && (req.addr == mbpwm_pkg::A_CTRL);
  wire wr_action = req.wr && (req.addr == mbpwm_pkg::A_ACTION);
  wire wr_mode   = req.wr && (req.addr == mbpwm_pkg::A_MODE);
  wire wr_stat   = req.wr && (req.addr == mbpwm_pkg::A_STAT);
  wire wr_mask   = req.wr && (req.addr == mbpwm_pkg::A_MASK);
  wire wr_match  = req.wr && in_match;

  // match detection against the running count
  logic [N_MATCH-1:0] hit;
  logic [N_MATCH-1:0] rst_hit;
  logic [N_MATCH-1:0] stop_hit;
  genvar m;
  generate
    for (m = 0; m < N_MATCH; m++)
    begin : g_match
      assign hit[m]      = ctrl_r[mbpwm_pkg::CTRL_RUN] && (count_r == match_r[m]);
      assign rst_hit[m]  = hit[m] && action_r[m*mbpwm_pkg::ACT_W+mbpwm_pkg::ACT_RST];
      assign stop_hit[m] = hit[m] && action_r[m*mbpwm_pkg::ACT_W+mbpwm_pkg::ACT_STOP];
    end
  endgenerate

  wire any_rst  = |rst_hit;
  wire any_stop = |stop_hit;
  wire cyc_hit  = hit[0];

  // counter next value
  logic [mbpwm_pkg::CNT_W-1:0] count_nxt;
  always_comb
  begin
    count_nxt = count_r;
    if (ctrl_r[mbpwm_pkg::CTRL_CRST] || any_rst || cyc_hit)
      count_nxt = mbpwm_pkg::CNT_RST;
    else if (ctrl_r[mbpwm_pkg::CTRL_RUN] && !any_stop)
      count_nxt = count_r + mbpwm_pkg::CNT_ONE;
  end

  // output next values: single-edge uses match k+1, double-edge uses k and k+1
  logic [N_OUT-1:0] pwm_nxt;
  genvar k;
  generate
    for (k = 0; k < N_OUT; k++)
    begin : g_out
      wire en  = mode_r[mbpwm_pkg::MODE_EN+k];
      wire dbl = (k > 0) && mode_r[k];
      wire rise = dbl ? hit[(k > 0) ? k : 0] : cyc_hit;
      wire fall = hit[k+1];
      // fall wins a tie so a zero-width setting gives low
      assign pwm_nxt[k] = !en ? 1'b0 :
                          fall ? 1'b0 : rise ? 1'b1 : pwm_r[k];
    end
  endgenerate

  // read mux
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (req.addr)
      mbpwm_pkg::A_CTRL:   rd_mux = ctrl_r;
      mbpwm_pkg::A_COUNT:  rd_mux = count_r;
      mbpwm_pkg::A_ACTION: rd_mux = action_r;
      mbpwm_pkg::A_MODE:   rd_mux = mode_r;
      mbpwm_pkg::A_STAT:   rd_mux = 32'(stat_r);
      mbpwm_pkg::A_MASK:   rd_mux = 32'(mask_r);
      default:             rd_mux = in_match ? match_r[widx[2:0]] : 32'h0000_0000;
    endcase
  end

  // sticky flags: set wins over write-one-clear
  wire [N_MATCH-1:0] wclr = wr_stat ? req.wdata[N_MATCH-1:0] : '0;
  wire [N_MATCH-1:0] stat_nxt = (stat_r & ~wclr) | hit;

  // run and counter-hold control
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      ctrl_r <= 32'h0000_0000;
    else if (wr_ctrl)
      ctrl_r <= req.wdata;
  end

  // per-match reset and stop actions
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      action_r <= 32'h0000_0000;
    else if (wr_action)
      action_r <= req.wdata;
  end

  // output modes and enables
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      mode_r <= 32'h0000_0000;
    else if (wr_mode)
      mode_r <= req.wdata;
  end

  // interrupt mask, one bit per match
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      mask_r <= '0;
    else if (wr_mask)
      mask_r <= req.wdata[N_MATCH-1:0];
  end

  // match registers
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      for (int i = 0; i < N_MATCH; i++) match_r[i] <= 32'h0000_0000;
    else if (wr_match)
      match_r[widx[2:0]] <= req.wdata;
  end

  // counter, flags, outputs
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      count_r <= mbpwm_pkg::CNT_RST;
      stat_r  <= '0;
      pwm_r   <= '0;
      irq_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      count_r <= count_nxt;
      stat_r  <= stat_nxt;
      pwm_r   <= pwm_nxt;
      irq_r   <= |(stat_nxt & mask_r);
      rdata_r <= req.rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign rdata_o = rdata_r;
  assign pwm_o   = pwm_r;
  assign irq_o   = irq_r;

  // cycle match clears the count
  a_cycle_reset: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    cyc_hit && !ctrl_r[mbpwm_pkg::CTRL_CRST]
    |=> count_r == mbpwm_pkg::CNT_RST)
    else $error("count not cleared on cycle match");

  // free-running count steps by one
  a_count_step: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ctrl_r[mbpwm_pkg::CTRL_RUN] && !(|hit) && !ctrl_r[mbpwm_pkg::CTRL_CRST] && !req.wr
    |=> count_r == $past(count_r) + mbpwm_pkg::CNT_ONE)
    else $error("count did not advance");

  // stop match freezes the count
  a_stop_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    any_stop && !any_rst && !cyc_hit && !ctrl_r[mbpwm_pkg::CTRL_CRST] && !req.wr
    |=> count_r == $past(count_r))
    else $error("count moved after stop match");

  // reset match clears the count
  a_reset_match: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    any_rst
    |=> count_r == mbpwm_pkg::CNT_RST)
    else $error("count not cleared on reset match");

  // output 0 rises at the period start
  a_single_rise: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    cyc_hit && mode_r[mbpwm_pkg::MODE_EN] && !hit[1]
    |=> pwm_o[0])
    else $error("single edge output did not rise");

  // output 0 falls on its own match
  a_single_fall: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    hit[1]
    |=> !pwm_o[0])
    else $error("single edge output did not fall");

  // disabled output 0 stays low
  a_const_low: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !mode_r[mbpwm_pkg::MODE_EN]
    |=> !pwm_o[0])
    else $error("disabled output went high");

  // double-edge output 1 rises on its rise match
  a_double_rise: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    mode_r[1] && mode_r[mbpwm_pkg::MODE_EN+1] && hit[1] && !hit[2]
    |=> pwm_o[1])
    else $error("double edge output did not rise");

  // request follows the flags under the mask of the match cycle
  a_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    hit[0]
    |=> stat_r[0] && (irq_o == |(stat_r & $past(mask_r))))
    else $error("match flag or request wrong");

  // a stopped timer sees no match
  a_no_hit_idle: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !ctrl_r[mbpwm_pkg::CTRL_RUN]
    |-> hit == '0)
    else $error("match seen while stopped");

  // a stopped timer keeps its count
  a_run_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !ctrl_r[mbpwm_pkg::CTRL_RUN] && !ctrl_r[mbpwm_pkg::CTRL_CRST]
    |=> count_r == $past(count_r))
    else $error("count moved while stopped");

  // counter hold forces the start value
  a_hold_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ctrl_r[mbpwm_pkg::CTRL_CRST]
    |=> count_r == mbpwm_pkg::CNT_RST)
    else $error("count not held at start value");

  // count read returns the count of the read cycle
  a_read_count: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    req.rd && (req.addr == mbpwm_pkg::A_COUNT)
    |=> rdata_o == $past(count_r))
    else $error("count read wrong");

  // flag read returns the flags of the read cycle
  a_read_flags: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    req.rd && (req.addr == mbpwm_pkg::A_STAT)
    |=> rdata_o == 32'($past(stat_r)))
    else $error("flag read wrong");

  // match read returns the addressed match register
  a_read_match: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    req.rd && in_match
    |=> rdata_o == $past(match_r[widx[2:0]]))
    else $error("match register read wrong");

  // match write lands in the addressed register
  a_match_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wr_match
    |=> match_r[$past(widx[2:0])] == $past(req.wdata))
    else $error("match register write lost");

  // action write lands
  a_action_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wr_action
    |=> action_r == $past(req.wdata))
    else $error("action write lost");

  // mode write lands
  a_mode_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wr_mode
    |=> mode_r == $past(req.wdata))
    else $error("mode write lost");

  // mask write lands
  a_mask_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wr_mask
    |=> mask_r == $past(req.wdata[N_MATCH-1:0]))
    else $error("mask write lost");

  // every match sets its flag, also against a clear
  a_flag_set: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    |hit
    |=> (stat_r & $past(hit)) == $past(hit))
    else $error("match flag not set");

  // flags stay until written with a one
  a_flag_keep: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    |stat_r
    |=> (($past(stat_r) & ~$past(wclr)) & ~stat_r) == '0)
    else $error("match flag lost");

  // writing a one clears a quiet flag
  a_flag_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wr_stat && !(|hit)
    |=> (stat_r & $past(wclr)) == '0)
    else $error("match flag not cleared");

  // an enabled match raises the request
  a_irq_on_hit: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    |(hit & mask_r)
    |=> irq_o)
    else $error("request missing after enabled match");

  // no flag, no request
  a_irq_quiet: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (stat_r == '0) && !(|hit)
    |=> !irq_o)
    else $error("request without a flag");

  // edges of every output
  genvar q;
  generate
    for (q = 0; q < N_OUT; q++)
    begin : g_chk
      // single-edge output rises at the period start
      a_out_rise: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        mode_r[mbpwm_pkg::MODE_EN+q] && !mode_r[q] && hit[0] && !hit[q+1]
        |=> pwm_o[q])
        else $error("single edge output did not rise");

      // the fall match always drives the output low
      a_out_fall: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        hit[q+1]
        |=> !pwm_o[q])
        else $error("output did not fall");

      // a disabled output stays low
      a_out_off: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !mode_r[mbpwm_pkg::MODE_EN+q]
        |=> !pwm_o[q])
        else $error("disabled output went high");

      // double-edge output rises on its own rise match
      a_dbl_rise: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        mode_r[mbpwm_pkg::MODE_EN+q] && mode_r[q] && hit[q] && !hit[q+1]
        |=> pwm_o[q])
        else $error("double edge output did not rise");

      // with no edge event the level holds, also across the wrap
      a_out_keep: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        mode_r[mbpwm_pkg::MODE_EN+q] && !(mode_r[q] ? hit[q] : hit[0]) && !hit[q+1]
        |=> pwm_o[q] == $past(pwm_o[q]))
        else $error("output changed without an edge match");
    end
  endgenerate

  // main scenarios reached
  c_cycle: cover property (@(posedge ref_clk_i) cyc_hit);
  c_double: cover property (@(posedge ref_clk_i) mode_r[1] && hit[1] ##[1:50] hit[2]);
  c_negative: cover property (@(posedge ref_clk_i) mode_r[1] && hit[2] ##[1:50] hit[1]);
  c_stop: cover property (@(posedge ref_clk_i) any_stop);
  c_irq: cover property (@(posedge ref_clk_i) irq_o);
endmodule

/* File: inc/mbpwm_pkg.sv */
package mbpwm_pkg;
  localparam int CNT_W    = 32;
  localparam int N_MATCH  = 7;
  localparam int N_OUT    = 6;
  localparam int ADDR_W   = 8;
  // register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00; // bit0 run, bit1 counter reset
  localparam logic [7:0] A_COUNT  = 8'h04;
  localparam logic [7:0] A_ACTION = 8'h08; // per match: [3m+1]=reset,[3m+2]=stop
  localparam logic [7:0] A_MODE   = 8'h0c; // [k]=double-edge for k>0, [8+k]=output enable
  localparam logic [7:0] A_STAT   = 8'h10; // write one to clear
  localparam logic [7:0] A_MASK   = 8'h14;
  localparam logic [7:0] A_MATCH0 = 8'h20; // match m at A_MATCH0 + 4*m
  localparam logic [7:0] A_STEP   = 8'h04;
  localparam int CTRL_RUN   = 0;
  localparam int CTRL_CRST  = 1;
  localparam int ACT_IRQ    = 0;
  localparam int ACT_RST    = 1;
  localparam int ACT_STOP   = 2;
  localparam int ACT_W      = 3;
  localparam int MODE_EN    = 8;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } mbpwm_req_t;
endpackage

/* File: dv/mbpwm_timer_tb.sv */
`timescale 1ns/10ps
module mbpwm_timer_tb;
  logic        ref_clk_i;
  logic        reset_i;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  logic [5:0]  pwm_o;
  logic        irq_o;
  logic [31:0] exp_q[$];
  logic        rd_d;
  logic [31:0] seed;
  int          err_total;
  int          n_tests;
  int          hi[6];
  int          p, r, f, w;

  mbpwm_timer mbpwm_timer_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pwm_o(pwm_o), .irq_o(irq_o));

  // clock, 8 ns period
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle bus strobes, idle cycle between calls
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    exp_q.push_back(exp);
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
  endtask

  // read data checker: oldest note against the returned word
  always @(posedge ref_clk_i)
  begin
    rd_d <= rd_i;
    if (rd_d === 1'b1)
      chk(rdata_o, exp_q.pop_front());
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // out0 single on match1, out1 double match1/match2, out2 single on match3,
  // out3 double rising on match3 and falling on match4 (left at 6)
  task automatic pwm_run(input int rr, input int ff);
    wr(8'h00, 32'h0000_0002);
    wr(8'h24, 32'(rr));
    wr(8'h28, 32'(ff));
    wr(8'h00, 32'h0000_0001);
    repeat (3 * p) @(posedge ref_clk_i);
    hi = '{default: 0};
    repeat (4 * p)
    begin
      @(posedge ref_clk_i);
      for (int k = 0; k < 6; k++) hi[k] += int'(pwm_o[k] === 1'b1);
    end
    chk(32'(hi[0]), 32'(4 * (rr + 1)));
    chk(32'(hi[1]), 32'(4 * (rr < ff ? ff - rr : p - rr + ff)));
    chk(32'(hi[2]), 32'(4 * (w + 1)));
    chk(32'(hi[3]), 32'(4 * (p - w + 6)));
    chk(32'(hi[4] + hi[5]), 32'h0);
    $display("pwm test done");
  endtask

  // main sequence
  initial
  begin
    seed = 32'h0000_2f28;
    {addr_i, wdata_i, wr_i, rd_i} = '0;
    reset_i = 1'b1;
    repeat (20) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    foreach (hi[k]) rd(8'(4 * k), 32'h0);
    $display("reset test done");
    for (int m = 0; m < 7; m++) wr(8'h20 + 8'(4 * m), 32'h0000_1000);
    wr(8'h28, 32'h0000_0009);
    wr(8'h08, 32'h0000_0100);
    wr(8'h10, 32'h0000_007f);
    wr(8'h14, 32'h0000_0004);
    wr(8'h00, 32'h0000_0001);
    repeat (40) @(posedge ref_clk_i);
    rd(8'h04, 32'h0000_0009);
    rd(8'h10, 32'h0000_0004);
    repeat (3) @(posedge ref_clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wr(8'h14, 32'h0);
    repeat (3) @(posedge ref_clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wr(8'h00, 32'h0000_0002);
    wr(8'h10, 32'h0000_007f);
    rd(8'h10, 32'h0);
    $display("stop test done");
    // reset on match3 keeps the stop on match4 from being reached
    wr(8'h24, 32'h0000_0002);
    wr(8'h2c, 32'h0000_0005);
    wr(8'h30, 32'h0000_0006);
    wr(8'h08, 32'h0000_4400);
    wr(8'h00, 32'h0000_0001);
    repeat (40) @(posedge ref_clk_i);
    rd(8'h10, 32'h0000_000a);
    wr(8'h18, 32'hffff_ffff);
    rd(8'h18, 32'h0);
    rd(8'h3c, 32'h0);
    rd(8'h60, 32'h0);
    $display("action test done");
    p = 20 + int'(rnd() % 20);
    r = 2 + int'(rnd() % 5);
    f = r + 3 + int'(rnd() % 5);
    w = f + 2;
    wr(8'h08, 32'h0);
    wr(8'h20, 32'(p - 1));
    wr(8'h2c, 32'(w));
    wr(8'h0c, 32'h0000_0f0a);
    pwm_run(r, f);
    pwm_run(f, r);
    repeat (4) @(posedge ref_clk_i);
    results();
  end

  // watchdog, far beyond the fewer than a thousand cycles the tests need
  initial
  begin
    #200000;
    err_total++;
    results();
  end
endmodule
